// File: core/tccm_core.sv
// Timer capture, compare and interrupt-flag core with byte-wide register port
// What this block does
// R1 - Copy counter into capture register on each capture event, pin or comparator.
// R2 - Capture register can serve as counter top, chosen by waveform mode.
// R3 - Capture or counter read gives coherent 16 bits via shared temp byte.
// R4 - Compare writes stage high byte in temp, update both on low write.
// R5 - Compare both compare registers against counter on every timer clock.
// R6 - Compare match raises flag and toggles the compare output pin.
// R7 - Capture interrupt requested when mask bit 5, global enable, flag all set.
// R8 - Match B interrupt requested when mask bit 2, global enable, flag set.
// R9 - Match A interrupt requested when mask bit 1, global enable, flag set.
// R10 - Overflow interrupt requested when mask bit 0, global enable, flag set.
// R11 - Capture event sets capture flag, bit 5.
// R12 - With capture as top, flag sets when counter reaches top instead.
// R13 - Capture flag clears on vector execution or writing one.
// R14 - Match B flag, bit 2, sets the timer clock after equality.
// R15 - Match A flag, bit 1, sets the timer clock after equality.
// R16 - Force-compare strobes never set a match flag.
// R17 - Match B flag clears on vector execution or writing one.
// R18 - Match A flag clears on vector execution or writing one.
// R19 - Overflow flag, bit 0, sets on overflow in normal/CLEAR_ON_MATCH_MODE; else at top.
// R20 - Overflow flag clears on vector execution or writing one.
// R21 - Flag register answers at data offset 0x36 and I/O offset 0x16.
// R22 - Counter write suppresses compare match on next timer clock.
// R23 - Edge select zero picks falling capture edge, one picks rising.
// R24 - Writing zero keeps a flag; hardware set beats same-cycle clear.
// R25 - Values and flags reset to zero; mask bits reset disabled.
`timescale 1ns/1ns
`include "tccm_map.svh"
module tccm_core
  import tccm_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // Byte-wide register port
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             reg_io_space_i,
  input  wire logic             reg_write_i,
  input  wire logic             reg_read_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic      [7:0]       reg_rdata_o,
  // Timer control
  input  wire logic             timer_tick_i,
  input  wire logic [3:0]       waveform_mode_field_i,
  input  wire logic             capture_edge_select_i,
  input  wire logic             capture_from_comparator_i,
  input  wire logic             force_match_a_strobe_i,
  input  wire logic             force_match_b_strobe_i,
  // Pins and comparator
  input  wire logic             capture_input_pin_i,
  input  wire logic             comparator_i,
  output logic                  compare_a_pin_o,
  output logic                  compare_b_pin_o,
  // Interrupt side of the core
  input  wire logic             global_irq_enable_i,
  input  wire logic             capture_vector_i,
  input  wire logic             match_b_vector_i,
  input  wire logic             match_a_vector_i,
  input  wire logic             overflow_vector_i,
  output logic                  capture_irq_o,
  output logic                  match_b_irq_o,
  output logic                  match_a_irq_o,
  output logic                  overflow_irq_o,
  // Observation
  output logic      [WIDTH-1:0] counter_value_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [WIDTH-1:0] counter_value;
  logic [WIDTH-1:0] capture_value;
  logic [WIDTH-1:0] compare_a_value;
  logic [WIDTH-1:0] compare_b_value;
  logic [7:0]       temp_high;
  logic [7:0]       timer_irq_mask;
  logic [7:0]       timer_irq_flags;
  logic             match_block;
  logic [7:0]       eff_addr;
  logic             addr_ok;
  logic             pin_event;
  logic             capture_source;
  tccm_top_type     top_kind;
  logic [WIDTH-1:0] top_value;
  logic             at_top;
  logic             at_max;
  logic             capture_event;
  logic             capture_at_top;
  logic             match_a_hit;
  logic             match_b_hit;
  logic             overflow_hit;
  logic             counter_write;
  logic [7:0]       set_flags;
  logic [7:0]       clear_flags;
  logic [7:0]       next_flags;
  logic [7:0]       next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding

  function automatic tccm_top_type top_of(input logic [3:0] mode);
    case (mode)
      4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: top_of = TCCM_TOP_FIXED;
      4'h8, 4'hA, 4'hE:                   top_of = TCCM_TOP_CAPTURE;
      4'hC:                               top_of = TCCM_TOP_CTC_CAP;
      4'h4, 4'h9, 4'hB, 4'hF:             top_of = TCCM_TOP_CMPA;
      default:                            top_of = TCCM_TOP_MAX;
    endcase
  endfunction

  function automatic logic [WIDTH-1:0] fixed_top(input logic [3:0] mode);
    case (mode)
      4'h1, 4'h5: fixed_top = WIDTH'(`TCCM_TOP_8BIT);
      4'h2, 4'h6: fixed_top = WIDTH'(`TCCM_TOP_9BIT);
      default:    fixed_top = WIDTH'(`TCCM_TOP_10BIT);
    endcase
  endfunction

  // Capture register in use as top: pin capture is disconnected
  function automatic logic uses_capture_top(input tccm_top_type kind);
    uses_capture_top = (kind == TCCM_TOP_CAPTURE) || (kind == TCCM_TOP_CTC_CAP);
  endfunction

  assign top_kind = top_of(waveform_mode_field_i);

  always_comb begin
    case (top_kind)
      TCCM_TOP_FIXED:   top_value = fixed_top(waveform_mode_field_i);
      TCCM_TOP_CAPTURE: top_value = capture_value; // [R2]
      TCCM_TOP_CTC_CAP: top_value = capture_value; // [R2]
      TCCM_TOP_CMPA:    top_value = compare_a_value;
      default:          top_value = WIDTH'(`TCCM_COUNT_MAX);
    endcase
  end

  assign at_top = (counter_value == top_value);
  assign at_max = (counter_value == WIDTH'(`TCCM_COUNT_MAX));

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // I/O space only reaches the low 64 locations, shifted up by the offset
  assign eff_addr = reg_io_space_i ? (reg_addr_i + `TCCM_IO_OFFSET) : reg_addr_i; // [R21]
  assign addr_ok  = !reg_io_space_i || (reg_addr_i < `TCCM_IO_LIMIT);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target, input logic ok);
    hit = ok && (a == target);
  endfunction

  assign counter_write = reg_write_i && hit(eff_addr, `TCCM_ADDR_COUNT_LOW, addr_ok);

  ////////////////////////////////////////////////////////////////////////////
  // Capture input

  // Source mux sits ahead of the synchroniser so both paths get filtered
  assign capture_source = capture_from_comparator_i ? comparator_i : capture_input_pin_i; // [R1]

  tccm_pin_sync u_capture_sync (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .pin_i        (capture_source),
    .rising_sel_i (capture_edge_select_i), // [R23]
    .event_o      (pin_event)
  );

  assign capture_event  = pin_event && !uses_capture_top(top_kind);
  assign capture_at_top = uses_capture_top(top_kind) && timer_tick_i && at_top; // [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      counter_value <= WIDTH'(`TCCM_RESET_WORD);
    end else if (counter_write) begin
      counter_value <= {temp_high, reg_wdata_i};
    end else if (timer_tick_i) begin
      if (at_top && (top_kind != TCCM_TOP_MAX)) begin
        counter_value <= WIDTH'(`TCCM_RESET_WORD);
      end else begin
        counter_value <= counter_value + WIDTH'(1);
      end
    end
  end

  assign counter_value_o = counter_value;

  // Counter write blanks the next timer clock's compare
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      match_block <= 1'b0;
    end else if (counter_write) begin
      match_block <= 1'b1; // [R22]
    end else if (timer_tick_i) begin
      match_block <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and overflow detection

  assign match_a_hit = timer_tick_i && !match_block && (counter_value == compare_a_value); // [R5] [R22]
  assign match_b_hit = timer_tick_i && !match_block && (counter_value == compare_b_value); // [R5] [R22]

  always_comb begin
    case (waveform_mode_field_i)
      TCCM_MODE_NORMAL, TCCM_MODE_CTC_CMPA, TCCM_MODE_CTC_CAP:
        overflow_hit = timer_tick_i && at_max; // [R19]
      default:
        overflow_hit = timer_tick_i && at_top; // [R19]
    endcase
  end

  // Forced compares toggle the pin but never reach the flags
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      compare_a_pin_o <= 1'b0;
      compare_b_pin_o <= 1'b0;
    end else begin
      if (match_a_hit || force_match_a_strobe_i) begin
        compare_a_pin_o <= !compare_a_pin_o; // [R6]
      end
      if (match_b_hit || force_match_b_strobe_i) begin
        compare_b_pin_o <= !compare_b_pin_o; // [R6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sixteen-bit registers and shared temp byte

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      temp_high <= `TCCM_RESET_BYTE;
    end else if (reg_write_i && (hit(eff_addr, `TCCM_ADDR_COUNT_HIGH, addr_ok) ||
                                 hit(eff_addr, `TCCM_ADDR_CAPT_HIGH, addr_ok) ||
                                 hit(eff_addr, `TCCM_ADDR_CMPA_HIGH, addr_ok) ||
                                 hit(eff_addr, `TCCM_ADDR_CMPB_HIGH, addr_ok))) begin
      temp_high <= reg_wdata_i; // [R4]
    end else if (reg_read_i && hit(eff_addr, `TCCM_ADDR_COUNT_LOW, addr_ok)) begin
      temp_high <= counter_value[WIDTH-1:8]; // [R3]
    end else if (reg_read_i && hit(eff_addr, `TCCM_ADDR_CAPT_LOW, addr_ok)) begin
      temp_high <= capture_value[WIDTH-1:8]; // [R3]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      capture_value <= WIDTH'(`TCCM_RESET_WORD); // [R25]
    end else if (capture_event) begin
      capture_value <= counter_value; // [R1]
    end else if (reg_write_i && hit(eff_addr, `TCCM_ADDR_CAPT_LOW, addr_ok)) begin
      capture_value <= {temp_high, reg_wdata_i}; // [R4]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      compare_a_value <= WIDTH'(`TCCM_RESET_WORD); // [R25]
    end else if (reg_write_i && hit(eff_addr, `TCCM_ADDR_CMPA_LOW, addr_ok)) begin
      compare_a_value <= {temp_high, reg_wdata_i}; // [R4]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      compare_b_value <= WIDTH'(`TCCM_RESET_WORD); // [R25]
    end else if (reg_write_i && hit(eff_addr, `TCCM_ADDR_CMPB_LOW, addr_ok)) begin
      compare_b_value <= {temp_high, reg_wdata_i}; // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask and flags

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      timer_irq_mask <= `TCCM_RESET_BYTE; // [R25]
    end else if (reg_write_i && hit(eff_addr, `TCCM_ADDR_MASK, addr_ok)) begin
      timer_irq_mask <= reg_wdata_i & `TCCM_IRQ_BITS_MASK;
    end
  end

  always_comb begin
    set_flags   = 8'h00;
    clear_flags = 8'h00;
    set_flags[`TCCM_BIT_CAPTURE]  = capture_event || capture_at_top; // [R11] [R12]
    set_flags[`TCCM_BIT_MATCH_B]  = match_b_hit; // [R14] [R16]
    set_flags[`TCCM_BIT_MATCH_A]  = match_a_hit; // [R15] [R16]
    set_flags[`TCCM_BIT_OVERFLOW] = overflow_hit; // [R19]
    if (reg_write_i && hit(eff_addr, `TCCM_ADDR_FLAGS, addr_ok)) begin
      clear_flags = reg_wdata_i & `TCCM_IRQ_BITS_MASK; // [R24]
    end
    clear_flags[`TCCM_BIT_CAPTURE]  = clear_flags[`TCCM_BIT_CAPTURE] || capture_vector_i; // [R13]
    clear_flags[`TCCM_BIT_MATCH_B]  = clear_flags[`TCCM_BIT_MATCH_B] || match_b_vector_i; // [R17]
    clear_flags[`TCCM_BIT_MATCH_A]  = clear_flags[`TCCM_BIT_MATCH_A] || match_a_vector_i; // [R18]
    clear_flags[`TCCM_BIT_OVERFLOW] = clear_flags[`TCCM_BIT_OVERFLOW] || overflow_vector_i; // [R20]
    // Set applied last so a same-cycle event is never lost
    next_flags = ((timer_irq_flags & ~clear_flags) | set_flags) & `TCCM_IRQ_BITS_MASK; // [R24]
  end

  // Flag is set at the edge after equality, so it shows one timer clock later
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      timer_irq_flags <= `TCCM_RESET_BYTE; // [R25]
    end else begin
      timer_irq_flags <= next_flags; // [R14] [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests

  assign capture_irq_o  = timer_irq_mask[`TCCM_BIT_CAPTURE] && global_irq_enable_i &&
                          timer_irq_flags[`TCCM_BIT_CAPTURE]; // [R7]
  assign match_b_irq_o  = timer_irq_mask[`TCCM_BIT_MATCH_B] && global_irq_enable_i &&
                          timer_irq_flags[`TCCM_BIT_MATCH_B]; // [R8]
  assign match_a_irq_o  = timer_irq_mask[`TCCM_BIT_MATCH_A] && global_irq_enable_i &&
                          timer_irq_flags[`TCCM_BIT_MATCH_A]; // [R9]
  assign overflow_irq_o = timer_irq_mask[`TCCM_BIT_OVERFLOW] && global_irq_enable_i &&
                          timer_irq_flags[`TCCM_BIT_OVERFLOW]; // [R10]

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    next_rdata = 8'h00;
    if (addr_ok) begin
      case (eff_addr)
        `TCCM_ADDR_FLAGS:      next_rdata = timer_irq_flags; // [R21]
        `TCCM_ADDR_MASK:       next_rdata = timer_irq_mask;
        `TCCM_ADDR_COUNT_LOW:  next_rdata = counter_value[7:0];
        `TCCM_ADDR_COUNT_HIGH: next_rdata = temp_high; // [R3]
        `TCCM_ADDR_CAPT_LOW:   next_rdata = capture_value[7:0];
        `TCCM_ADDR_CAPT_HIGH:  next_rdata = temp_high; // [R3]
        `TCCM_ADDR_CMPA_LOW:   next_rdata = compare_a_value[7:0];
        `TCCM_ADDR_CMPA_HIGH:  next_rdata = compare_a_value[WIDTH-1:8];
        `TCCM_ADDR_CMPB_LOW:   next_rdata = compare_b_value[7:0];
        `TCCM_ADDR_CMPB_HIGH:  next_rdata = compare_b_value[WIDTH-1:8];
        default:               next_rdata = 8'h00;
      endcase
    end
  end

  // Data held until the next read
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= `TCCM_RESET_BYTE;
    end else if (reg_read_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule // tccm_core

// File: core/tccm_map.svh
// Register offsets, bit positions and reset values of the timer capture/compare block
`ifndef TCCM_MAP_SVH
`define TCCM_MAP_SVH

// Data-space byte offsets
`define TCCM_ADDR_FLAGS      8'h36
`define TCCM_ADDR_MASK       8'h6F
`define TCCM_ADDR_COUNT_LOW  8'h84
`define TCCM_ADDR_COUNT_HIGH 8'h85
`define TCCM_ADDR_CAPT_LOW   8'h86
`define TCCM_ADDR_CAPT_HIGH  8'h87
`define TCCM_ADDR_CMPA_LOW   8'h88
`define TCCM_ADDR_CMPA_HIGH  8'h89
`define TCCM_ADDR_CMPB_LOW   8'h8A
`define TCCM_ADDR_CMPB_HIGH  8'h8B

// Short I/O space sits this far below data space
`define TCCM_IO_OFFSET       8'h20
`define TCCM_IO_LIMIT        8'h40

// Flag and mask bit positions
`define TCCM_BIT_CAPTURE     5
`define TCCM_BIT_MATCH_B     2
`define TCCM_BIT_MATCH_A     1
`define TCCM_BIT_OVERFLOW    0

// Implemented bits of flags and mask
`define TCCM_IRQ_BITS_MASK   8'h27

// Reset values
`define TCCM_RESET_BYTE      8'h00
`define TCCM_RESET_WORD      16'h0000

// Counter limits
`define TCCM_COUNT_MAX       16'hFFFF
`define TCCM_TOP_8BIT        16'h00FF
`define TCCM_TOP_9BIT        16'h01FF
`define TCCM_TOP_10BIT       16'h03FF

`endif

// File: core/tccm_pkg.sv
// Types of the timer capture/compare block
package tccm_pkg;

  // Where the counter top value comes from (one-hot)
  typedef enum logic [4:0] {
    TCCM_TOP_MAX     = 5'b00001,
    TCCM_TOP_FIXED   = 5'b00010,
    TCCM_TOP_CAPTURE = 5'b00100,
    TCCM_TOP_CMPA    = 5'b01000,
    TCCM_TOP_CTC_CAP = 5'b10000
  } tccm_top_type;

  // Waveform mode field values with special handling
  typedef enum logic [3:0] {
    TCCM_MODE_NORMAL   = 4'h0,
    TCCM_MODE_CTC_CMPA = 4'h4,
    TCCM_MODE_CTC_CAP  = 4'hC
  } tccm_mode_type;

endpackage

// File: core/tccm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge select
`timescale 1ns/1ns
module tccm_pin_sync (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // Pin side
  input  wire logic pin_i,
  input  wire logic rising_sel_i,
  // Event side
  output logic      event_o
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;

  // Stages run through reset, so a pin idling high gives no false edge
  always_ff @(posedge clock_i) begin
    stage1 <= pin_i;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  // Level only moves once the last two stages agree
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      level <= stage3;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      event_o <= 1'b0;
    end else begin
      event_o <= (stage2 == stage3) && (stage3 != level) && (stage3 == rising_sel_i);
    end
  end

endmodule // tccm_pin_sync

// File: tb/tccm_core_props.sv
// Concurrent checks on the ports of the timer capture/compare core
`timescale 1ns/1ns
module tccm_core_props #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic             clock_i,
  input wire logic             rst_i,
  // Register port
  input wire logic             reg_write_i,
  input wire logic [7:0]       reg_rdata_o,
  // Interrupt side
  input wire logic             global_irq_enable_i,
  input wire logic             match_b_vector_i,
  input wire logic             match_a_vector_i,
  input wire logic             capture_irq_o,
  input wire logic             match_b_irq_o,
  input wire logic             match_a_irq_o,
  input wire logic             overflow_irq_o,
  // Pins and counter
  input wire logic             compare_a_pin_o,
  input wire logic             compare_b_pin_o,
  input wire logic [WIDTH-1:0] counter_value_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////
  // Vector with no fresh match in the same cycle
  sequence s_vec_a;
    match_a_vector_i ##1 $stable(compare_a_pin_o);
  endsequence
  sequence s_vec_b;
    match_b_vector_i ##1 $stable(compare_b_pin_o);
  endsequence
  // Enable and mask untouched, so a rising request can only come from a flag
  sequence s_quiet;
    global_irq_enable_i && $past(global_irq_enable_i) && !$past(reg_write_i);
  endsequence

  ////////////////////////////////////////////////////////////////
  a_cap_gate: assert property (!global_irq_enable_i |-> !capture_irq_o)
    else $error("capture request without global enable");
  a_b_gate: assert property (!global_irq_enable_i |-> !match_b_irq_o)
    else $error("match B request without global enable");
  a_a_gate: assert property (!global_irq_enable_i |-> !match_a_irq_o)
    else $error("match A request without global enable");
  a_ovf_gate: assert property (!global_irq_enable_i |-> !overflow_irq_o)
    else $error("overflow request without global enable");
  a_vec_clear_a: assert property (s_vec_a |-> !match_a_irq_o)
    else $error("match A flag survived its vector");
  a_vec_clear_b: assert property (s_vec_b |-> !match_b_irq_o)
    else $error("match B flag survived its vector");
  a_match_a_pin: assert property (s_quiet ##0 $rose(match_a_irq_o) |-> $changed(compare_a_pin_o))
    else $error("match A flag without its pin change");
  a_match_b_pin: assert property (s_quiet ##0 $rose(match_b_irq_o) |-> $changed(compare_b_pin_o))
    else $error("match B flag without its pin change");
  a_reset_zero: assert property ($fell(rst_i) |-> reg_rdata_o == 8'h00 && counter_value_o == '0
    && !compare_a_pin_o && !compare_b_pin_o && !capture_irq_o && !overflow_irq_o)
    else $error("state not cleared by reset");
endmodule // tccm_core_props

bind tccm_core tccm_core_props #(.WIDTH(WIDTH)) u_tccm_core_props (
  .clock_i(clock_i), .rst_i(rst_i), .reg_write_i(reg_write_i), .reg_rdata_o(reg_rdata_o),
  .global_irq_enable_i(global_irq_enable_i), .match_b_vector_i(match_b_vector_i),
  .match_a_vector_i(match_a_vector_i), .capture_irq_o(capture_irq_o), .match_b_irq_o(match_b_irq_o),
  .match_a_irq_o(match_a_irq_o), .overflow_irq_o(overflow_irq_o), .compare_a_pin_o(compare_a_pin_o),
  .compare_b_pin_o(compare_b_pin_o), .counter_value_o(counter_value_o)
);

// File: tb/tccm_cpu_model.sv
// Processor core stand-in that executes interrupt vectors
`timescale 1ns/1ns
module tccm_cpu_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Interrupt handshake
  input  wire logic       ack_enable_i,
  input  wire logic [3:0] irq_i,
  output logic      [3:0] vector_o
);
  // One-cycle vector per request; the gap avoids a double clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      vector_o <= 4'h0;
    end else begin
      vector_o <= irq_i & {4{ack_enable_i}} & ~vector_o;
    end
  end
endmodule // tccm_cpu_model

// File: tb/tb_top.sv
// Self-checking bench for the timer capture/compare core
`timescale 1ns/1ns
module tb_top;
  logic       clock_i  = 1'b0;
  logic       rst_i    = 1'b1;
  logic [7:0] addr     = 8'h00;
  logic       io_space = 1'b0;
  logic       wr_en    = 1'b0;
  logic       rd_en    = 1'b0;
  logic [7:0] wdata    = 8'h00;
  logic       tick     = 1'b0;
  logic       rise_sel = 1'b0;
  logic       force_a  = 1'b0;
  logic       force_b  = 1'b0;
  logic       cap_pin  = 1'b0;
  logic       gie      = 1'b0;
  logic       ack_en   = 1'b0;
  logic       cmp_sel  = 1'b0;
  logic       comp     = 1'b0;
  logic [3:0] mode     = 4'h0;
  logic [7:0] rdata;
  logic [3:0] vec;
  wire  [3:0] irqs;
  logic [15:0] cnt;
  logic       pin_a;
  logic       pin_b;
  int         err_count  = 0;
  int         n_compared = 0;
  logic [7:0] regs [10] = '{8'h36, 8'h6F, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B};

  always #50 clock_i = ~clock_i;

  tccm_core u_tccm_core (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_io_space_i(io_space),
    .reg_write_i(wr_en), .reg_read_i(rd_en), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .timer_tick_i(tick), .waveform_mode_field_i(mode), .capture_edge_select_i(rise_sel),
    .capture_from_comparator_i(cmp_sel), .force_match_a_strobe_i(force_a), .force_match_b_strobe_i(force_b),
    .capture_input_pin_i(cap_pin), .comparator_i(comp), .compare_a_pin_o(pin_a), .compare_b_pin_o(pin_b),
    .global_irq_enable_i(gie), .capture_vector_i(vec[3]), .match_b_vector_i(vec[2]),
    .match_a_vector_i(vec[1]), .overflow_vector_i(vec[0]), .capture_irq_o(irqs[3]),
    .match_b_irq_o(irqs[2]), .match_a_irq_o(irqs[1]), .overflow_irq_o(irqs[0]), .counter_value_o(cnt)
  );

  tccm_cpu_model u_tccm_cpu_model (
    .clock_i(clock_i), .rst_i(rst_i), .ack_enable_i(ack_en), .irq_i(irqs), .vector_o(vec)
  );

  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("errors=%0d compared=%0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Strobes last one cycle and drop at the next falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b0);
    @(negedge clock_i);
    addr = a;
    wdata = d;
    io_space = io;
    wr_en = 1'b1;
    @(negedge clock_i);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic io = 1'b0);
    @(negedge clock_i);
    addr = a;
    io_space = io;
    rd_en = 1'b1;
    @(negedge clock_i);
    rd_en = 1'b0;
    chk({8'h00, rdata}, {8'h00, e});
  endtask

  // High byte first: it only stages until the low byte lands
  task automatic wr16(input logic [7:0] lo_addr, input logic [15:0] v);
    wr(lo_addr + 8'h01, v[15:8]);
    wr(lo_addr, v[7:0]);
  endtask

  task automatic wait_irq(input logic [3:0] m);
    int n;
    n = 0;
    while (((irqs & m) == m) !== 1'b1 && n < 300) begin
      @(negedge clock_i);
      n++;
    end
    chk({12'h000, irqs & m}, {12'h000, m});
    if (n >= 300) complete_run();
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    idle(20);
    rst_i = 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(8'h80, 8'h00);
    rd(8'h40, 8'h00, 1'b1);
    wr(8'h6F, 8'hFF);
    rd(8'h6F, 8'h27);
    wr(8'h89, 8'h12);
    rd(8'h89, 8'h00);
    wr(8'h88, 8'h34);
    rd(8'h89, 8'h12);
    rd(8'h88, 8'h34);
    wr16(8'h88, 16'h0010);
    wr16(8'h8A, 16'h0040);
    rd(8'h8A, 8'h40);
    // Match A, flag through both address spaces
    gie = 1'b1;
    wr(8'h6F, 8'h02);
    wr16(8'h84, 16'h0008);
    tick = 1'b1;
    wait_irq(4'h2);
    tick = 1'b0;
    chk({15'h0000, pin_a}, 16'h0001);
    rd(8'h16, 8'h02, 1'b1);
    wr(8'h36, 8'h00);
    rd(8'h36, 8'h02);
    wr(8'h16, 8'h02, 1'b1);
    rd(8'h36, 8'h00);
    force_a = 1'b1;
    force_b = 1'b1;
    idle(1);
    force_a = 1'b0;
    force_b = 1'b0;
    chk({14'h0000, pin_a, pin_b}, 16'h0001);
    rd(8'h36, 8'h00);
    // Counter written onto the compare value while running
    tick = 1'b1;
    wr16(8'h84, 16'h0010);
    idle(4);
    tick = 1'b0;
    rd(8'h36, 8'h00);
    // Match B, then overflow and match A, each cleared by its vector
    ack_en = 1'b1;
    wr(8'h6F, 8'h04);
    wr16(8'h84, 16'h003C);
    tick = 1'b1;
    wait_irq(4'h4);
    idle(3);
    tick = 1'b0;
    rd(8'h36, 8'h00);
    wr(8'h6F, 8'h03);
    wr16(8'h84, 16'hFFFC);
    tick = 1'b1;
    wait_irq(4'h1);
    wait_irq(4'h2);
    idle(3);
    tick = 1'b0;
    rd(8'h36, 8'h00);
    // Capture on the selected edge only
    ack_en = 1'b0;
    wr(8'h6F, 8'h20);
    wr16(8'h84, 16'h5A3C);
    cap_pin = 1'b1;
    idle(10);
    rd(8'h36, 8'h00);
    cap_pin = 1'b0;
    wait_irq(4'h8);
    rd(8'h86, 8'h3C);
    rd(8'h87, 8'h5A);
    wr(8'h36, 8'h20);
    rd(8'h36, 8'h00);
    rise_sel = 1'b1;
    wr16(8'h84, 16'h0102);
    cap_pin = 1'b1;
    wait_irq(4'h8);
    rd(8'h86, 8'h02);
    rd(8'h87, 8'h01);
    rd(8'h84, 8'h02);
    rd(8'h85, 8'h01);
    gie = 1'b0;
    idle(1);
    chk({15'h0000, irqs[3]}, 16'h0000);
    rd(8'h36, 8'h20);
    // Comparator as capture source, then capture register as counter top
    gie = 1'b1;
    wr(8'h36, 8'h20);
    wr16(8'h84, 16'h0203);
    cmp_sel = 1'b1;
    idle(6);
    comp = 1'b1;
    wait_irq(4'h8);
    rd(8'h86, 8'h03);
    wr(8'h36, 8'h20);
    mode = 4'hC;
    wr16(8'h86, 16'h0008);
    wr16(8'h84, 16'h0000);
    tick = 1'b1;
    wait_irq(4'h8);
    tick = 1'b0;
    chk(cnt, 16'h0000);
    rd(8'h36, 8'h20);
    complete_run();
  end
endmodule // tb_top
